// [tt_proto_core.sv]
/*
  Protocol engine of a time-triggered dual-channel bus controller:
  wakeup sender, startup sequencing, host state view, measurement table
  clearing, correction limit checks, sync frame limit and rx filtering.
  Assumes bus pins are synchronised here; the host uses AXI4-Lite.
*/
`timescale 1ns/1ps
module tt_proto_core #(
  parameter int CLK_PER_MT = 4
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rx_frame_a,
  input wire logic rx_frame_b,
  input wire logic rx_sync,
  input wire logic rx_startup,
  input wire logic rx_null,
  input wire logic rx_wake_sym,
  input wire logic [31:0] rx_payload,
  input wire logic [10:0] rx_frame_id,
  input wire logic [5:0] rx_cycle,
  input wire logic [15:0] rx_msg_id,
  input wire logic [15:0] meas_offset,
  input wire logic [15:0] meas_rate,
  output logic tx_wake_a,
  output logic tx_wake_b,
  output logic tx_null_ind,
  output logic table_clr_even,
  output logic table_clr_odd,
  output logic fifo_accept,
  output logic buf_accept
);

  initial begin
    if (CLK_PER_MT < 1 || CLK_PER_MT > 255)
      $error("CLK_PER_MT out of range");
  end

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  localparam int NS = 7;
  logic [NS-1:0] sy1_reg, sy2_reg, pv_reg;
  logic [NS-1:0] sy_next;
  always_comb begin
    sy_next = {rx_wake_sym, rx_null, rx_startup, rx_sync, rx_frame_b,
               rx_frame_a, 1'b0};
  end
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sy1_reg <= '0;
      sy2_reg <= '0;
      pv_reg <= '0;
    end else if (ce) begin
      sy1_reg <= sy_next;
      sy2_reg <= sy1_reg;
      pv_reg <= sy2_reg;
    end
  end
  wire logic fa = sy2_reg[1] & ~pv_reg[1];
  wire logic fb = sy2_reg[2] & ~pv_reg[2];
  wire logic f_sync = sy2_reg[3];
  wire logic f_startup_frame_indicator = sy2_reg[4];
  // Wakeup input goes through the synchroniser and is then dropped
  wire logic f_null_n = sy2_reg[5];
  wire logic wake_seen = 1'b0 & sy2_reg[6];

  // ****************************************************************
  // Registers, protocol state and timebase
  // ****************************************************************
  logic [31:0] ctrl_reg, ctrl_next, wake_reg, wake_next;
  logic [31:0] ext_reg, ext_next, lim_reg, lim_next, filt_reg, filt_next;
  logic [31:0] rxd_reg, rxd_next;
  logic [15:0] off_reg, off_next, rate_reg, rate_next;
  logic [15:0] mt_reg, mt_next, host_mt_reg, host_mt_next;
  logic [7:0] div_reg, div_next;
  logic [15:0] wcnt_reg, wcnt_next;
  logic [3:0] rep_reg, rep_next, cold_reg, cold_next;
  logic [4:0] sa_reg, sa_next, sb_reg, sb_next, nsync_reg, nsync_next;
  logic odd_reg, odd_next, lag_reg, lag_next, left_rst_reg, left_rst_next;
  logic wake_err_reg, wake_err_next, mtp_reg, mtp_next;
  tt_proto_pkg::poc_state_e st_reg, st_next, host_st_reg, host_st_next;
  logic aw_reg, aw_next, w_reg, w_next, bv_reg, bv_next, rv_reg, rv_next;
  logic [7:0] awa_reg, awa_next;
  logic [31:0] wd_reg, wd_next, rd_reg, rd_next;
  logic [1:0] br_reg, br_next, rr_reg, rr_next;

  function automatic logic [15:0] clip(input logic [15:0] v,
                                       input logic [15:0] lim);
    logic [15:0] a;
    a = v[15] ? 16'(-v) : v;
    clip = (a > lim) ? (v[15] ? 16'(-lim) : lim) : v;
  endfunction

  wire logic mt_tick = (div_reg == 8'(CLK_PER_MT - 1));
  wire logic [15:0] cyc_len = ctrl_reg[31:16] == 16'h0 ?
    tt_proto_pkg::CYCLE_MT_RST : ctrl_reg[31:16];
  wire logic cyc_end = mt_tick && (mt_reg == 16'(cyc_len - 16'h1));
  wire logic in_nit = mt_reg >= 16'(cyc_len - tt_proto_pkg::NIT_MT_RST);
  wire logic startup = st_reg inside {tt_proto_pkg::ST_COLD_LISTEN,
    tt_proto_pkg::ST_COLD_START, tt_proto_pkg::ST_INTEG_LISTEN,
    tt_proto_pkg::ST_INIT_SCHED};
  wire logic [4:0] startup_frame_indicator_max = (sa_reg > sb_reg) ? sa_reg : sb_reg;
  wire logic wr_go = aw_reg && w_reg && !bv_reg;
  wire logic mt_rst = wr_go && awa_reg == tt_proto_pkg::CTRL_OFF &&
    wd_reg[tt_proto_pkg::CTRL_MTRST_BIT];
  wire logic fid_ok = rx_frame_id == filt_reg[10:0];
  wire logic cyc_ok = rx_cycle == filt_reg[21:16];
  wire logic ch_ok = (fa & filt_reg[24]) | (fb & filt_reg[25]);

  always_comb begin
    ctrl_next = ctrl_reg;
    wake_next = wake_reg;
    ext_next = ext_reg;
    lim_next = lim_reg;
    filt_next = filt_reg;
    rxd_next = rxd_reg;
    st_next = st_reg;
    div_next = mt_tick ? 8'h0 : 8'(div_reg + 8'h1);
    mt_next = mt_reg;
    host_mt_next = host_mt_reg;
    odd_next = odd_reg;
    wcnt_next = wcnt_reg;
    rep_next = rep_reg;
    cold_next = cold_reg;
    sa_next = sa_reg;
    sb_next = sb_reg;
    nsync_next = nsync_reg;
    off_next = off_reg;
    rate_next = rate_reg;
    lag_next = 1'b0;
    left_rst_next = left_rst_reg | (st_reg != tt_proto_pkg::ST_RESET);
    wake_err_next = wake_err_reg | wake_seen;
    mtp_next = mtp_reg;
    host_st_next = st_reg;
    if (mt_tick) begin
      // A pending count reset lands one macrotick late, internally only
      mt_next = (cyc_end || mtp_reg) ? 16'h0 : 16'(mt_reg + 16'h1);
      host_mt_next = mt_next;
      mtp_next = 1'b0;
    end
    if (cyc_end) begin
      odd_next = ~odd_reg;
      // Offset/rate limit applied to raw value, then external term added
      off_next = 16'(clip(meas_offset, lim_reg[15:0]) + ext_reg[15:0]);
      rate_next = 16'(clip(meas_rate, lim_reg[31:16]) + ext_reg[31:16]);
      sa_next = 5'h0;
      sb_next = 5'h0;
      nsync_next = 5'h0;
    end
    if (f_startup_frame_indicator && fa && sa_reg != 5'h1F) sa_next = 5'(sa_reg + 5'h1);
    if (f_startup_frame_indicator && fb && sb_reg != 5'h1F) sb_next = 5'(sb_reg + 5'h1);
    if (f_sync && (fa | fb) && nsync_reg < tt_proto_pkg::MAX_SYNC_NODES)
      nsync_next = 5'(nsync_reg + 5'h1);
    // Payload kept only in the normal state; startup bit never stored
    if ((fa | fb) && !startup && st_reg == tt_proto_pkg::ST_NORMAL)
      rxd_next = rx_payload;
    case (st_reg)
      tt_proto_pkg::ST_RESET: st_next = tt_proto_pkg::ST_CONFIG;
      tt_proto_pkg::ST_CONFIG: begin
        cold_next = ctrl_reg[7:4];
        if (ctrl_reg[tt_proto_pkg::CTRL_WAKE_BIT]) begin
          st_next = tt_proto_pkg::ST_WAKE_SEND;
          rep_next = wake_reg[7:4];
          wcnt_next = tt_proto_pkg::WAKE_SYM_CLK;
          ctrl_next[tt_proto_pkg::CTRL_WAKE_BIT] = 1'b0;
        end else if (ctrl_reg[tt_proto_pkg::CTRL_RUN_BIT]) begin
          st_next = ctrl_reg[tt_proto_pkg::CTRL_INHIBIT_BIT] ?
            tt_proto_pkg::ST_INTEG_LISTEN : tt_proto_pkg::ST_COLD_LISTEN;
        end
      end
      tt_proto_pkg::ST_WAKE_SEND: begin
        wcnt_next = 16'(wcnt_reg - 16'h1);
        if (wcnt_reg == 16'h0) begin
          wcnt_next = tt_proto_pkg::WAKE_SYM_CLK;
          rep_next = 4'(rep_reg - 4'h1);
          if (rep_reg <= 4'h1)
            st_next = tt_proto_pkg::ST_CONFIG;
        end
      end
      tt_proto_pkg::ST_COLD_LISTEN:
        if (cyc_end) st_next = tt_proto_pkg::ST_COLD_START;
      tt_proto_pkg::ST_COLD_START:
        if (cyc_end) begin
          if (startup_frame_indicator_max != 5'h0) st_next = tt_proto_pkg::ST_INIT_SCHED;
          else if (cold_reg == 4'h0) begin
            st_next = tt_proto_pkg::ST_INTEG_LISTEN;
            host_st_next = tt_proto_pkg::ST_COLD_LISTEN;
            lag_next = 1'b1;
          end else begin
            cold_next = 4'(cold_reg - 4'h1);
            st_next = tt_proto_pkg::ST_COLD_LISTEN;
          end
        end
      tt_proto_pkg::ST_INTEG_LISTEN:
        if (f_sync && (fa | fb)) st_next = tt_proto_pkg::ST_INIT_SCHED;
      tt_proto_pkg::ST_INIT_SCHED:
        if (cyc_end) st_next = tt_proto_pkg::ST_NORMAL;
      tt_proto_pkg::ST_NORMAL:
        if (!ctrl_reg[tt_proto_pkg::CTRL_RUN_BIT])
          st_next = tt_proto_pkg::ST_CONFIG;
      default: st_next = tt_proto_pkg::ST_RESET;
    endcase
    if (lag_reg && !mt_tick) begin
      lag_next = 1'b1;
      host_st_next = tt_proto_pkg::ST_COLD_LISTEN;
    end
    if (mt_rst) begin
      host_mt_next = 16'h0;
      mtp_next = 1'b1;
    end
    if (wr_go) begin
      case (awa_reg)
        tt_proto_pkg::CTRL_OFF: begin
          ctrl_next = wd_reg & 32'hFFFF_00F7;
          // Inhibit can still be set but no longer cleared once the reset state is left
          ctrl_next[tt_proto_pkg::CTRL_INHIBIT_BIT] = left_rst_reg ?
            (ctrl_reg[2] | wd_reg[2]) : wd_reg[2];
        end
        tt_proto_pkg::WAKE_OFF: wake_next = wd_reg & 32'h0000_00F3;
        tt_proto_pkg::EXTCORR_OFF: ext_next = wd_reg;
        tt_proto_pkg::LIMIT_OFF: lim_next = wd_reg;
        tt_proto_pkg::FILTER_OFF: filt_next = wd_reg;
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ctrl_reg <= tt_proto_pkg::CTRL_RST;
      wake_reg <= tt_proto_pkg::WAKE_RST;
      ext_reg <= '0;
      lim_reg <= tt_proto_pkg::LIMIT_RST;
      filt_reg <= '0;
      rxd_reg <= '0;
      st_reg <= tt_proto_pkg::ST_RESET;
      host_st_reg <= tt_proto_pkg::ST_RESET;
      div_reg <= '0;
      mt_reg <= '0;
      host_mt_reg <= '0;
      odd_reg <= 1'b0;
      wcnt_reg <= '0;
      rep_reg <= '0;
      cold_reg <= '0;
      sa_reg <= '0;
      sb_reg <= '0;
      nsync_reg <= '0;
      off_reg <= '0;
      rate_reg <= '0;
      lag_reg <= 1'b0;
      left_rst_reg <= 1'b0;
      wake_err_reg <= 1'b0;
      mtp_reg <= 1'b0;
    end else if (ce) begin
      ctrl_reg <= ctrl_next;
      wake_reg <= wake_next;
      ext_reg <= ext_next;
      lim_reg <= lim_next;
      filt_reg <= filt_next;
      rxd_reg <= rxd_next;
      st_reg <= st_next;
      host_st_reg <= host_st_next;
      div_reg <= div_next;
      mt_reg <= mt_next;
      host_mt_reg <= host_mt_next;
      odd_reg <= odd_next;
      wcnt_reg <= wcnt_next;
      rep_reg <= rep_next;
      cold_reg <= cold_next;
      sa_reg <= sa_next;
      sb_reg <= sb_next;
      nsync_reg <= nsync_next;
      off_reg <= off_next;
      rate_reg <= rate_next;
      lag_reg <= lag_next;
      left_rst_reg <= left_rst_next;
      wake_err_reg <= wake_err_next;
      mtp_reg <= mtp_next;
    end
  end

  // ****************************************************************
  // Link-side outputs
  // ****************************************************************
  wire logic sending = st_reg == tt_proto_pkg::ST_WAKE_SEND &&
    wcnt_reg > (tt_proto_pkg::WAKE_SYM_CLK >> 1);
  assign tx_wake_a = sending & wake_reg[tt_proto_pkg::WAKE_CHA_BIT];
  assign tx_wake_b = sending & wake_reg[tt_proto_pkg::WAKE_CHB_BIT];
  assign tx_null_ind = 1'b0;
  assign table_clr_even = in_nit & odd_reg;
  assign table_clr_odd = in_nit & ~odd_reg;
  // Message id filtering is offered to the FIFO path only
  assign fifo_accept = (fa | fb) & f_null_n & ~startup & ch_ok &
    ((rx_msg_id & filt_reg[31:16]) == filt_reg[31:16]);
  assign buf_accept = (fa | fb) & f_null_n & ~startup & ch_ok & fid_ok &
    cyc_ok;

  // ****************************************************************
  // AXI4-Lite slave
  // ****************************************************************
  always_comb begin
    aw_next = aw_reg;
    w_next = w_reg;
    awa_next = awa_reg;
    wd_next = wd_reg;
    bv_next = bv_reg;
    br_next = br_reg;
    rv_next = rv_reg;
    rd_next = rd_reg;
    rr_next = rr_reg;
    if (s_axi_awvalid && !aw_reg) begin
      aw_next = 1'b1;
      awa_next = {s_axi_awaddr[7:2], 2'b00};
    end
    if (s_axi_wvalid && !w_reg) begin
      w_next = 1'b1;
      wd_next = s_axi_wdata;
    end
    if (wr_go) begin
      aw_next = 1'b0;
      w_next = 1'b0;
      bv_next = 1'b1;
      br_next = (awa_reg > tt_proto_pkg::RXDATA_OFF) ?
        tt_proto_pkg::RESP_SLVERR : tt_proto_pkg::RESP_OKAY;
    end
    if (bv_reg && s_axi_bready) bv_next = 1'b0;
    if (rv_reg && s_axi_rready) rv_next = 1'b0;
    if (s_axi_arvalid && !rv_reg) begin
      rv_next = 1'b1;
      rr_next = tt_proto_pkg::RESP_OKAY;
      case ({s_axi_araddr[7:2], 2'b00})
        tt_proto_pkg::CTRL_OFF: rd_next = ctrl_reg;
        tt_proto_pkg::WAKE_OFF: rd_next = wake_reg;
        tt_proto_pkg::STATE_OFF: rd_next = {11'h0, nsync_reg, 7'h0,
          wake_err_reg, 4'(cold_reg), 4'(host_st_reg)};
        tt_proto_pkg::MTICK_OFF: rd_next = {15'h0, odd_reg, host_mt_reg};
        tt_proto_pkg::CORR_OFF: rd_next = {rate_reg, off_reg};
        tt_proto_pkg::EXTCORR_OFF: rd_next = ext_reg;
        tt_proto_pkg::LIMIT_OFF: rd_next = lim_reg;
        tt_proto_pkg::SYNC_OFF: rd_next = {11'h0, sb_reg, 11'h0, sa_reg};
        tt_proto_pkg::FILTER_OFF: rd_next = filt_reg;
        tt_proto_pkg::RXDATA_OFF: rd_next = rxd_reg;
        default: begin
          rd_next = '0;
          rr_next = tt_proto_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      aw_reg <= 1'b0;
      w_reg <= 1'b0;
      awa_reg <= '0;
      wd_reg <= '0;
      bv_reg <= 1'b0;
      br_reg <= '0;
      rv_reg <= 1'b0;
      rd_reg <= '0;
      rr_reg <= '0;
    end else if (ce) begin
      aw_reg <= aw_next;
      w_reg <= w_next;
      awa_reg <= awa_next;
      wd_reg <= wd_next;
      bv_reg <= bv_next;
      br_reg <= br_next;
      rv_reg <= rv_next;
      rd_reg <= rd_next;
      rr_reg <= rr_next;
    end
  end

  assign s_axi_awready = ce & ~aw_reg;
  assign s_axi_wready = ce & ~w_reg;
  assign s_axi_bvalid = bv_reg;
  assign s_axi_bresp = br_reg;
  assign s_axi_arready = ce & ~rv_reg;
  assign s_axi_rvalid = rv_reg;
  assign s_axi_rdata = rd_reg;
  assign s_axi_rresp = rr_reg;

endmodule

// [tt_proto_pkg.sv]
/*
  Package for the time-triggered protocol core: register map, field
  positions, reset values, state encodings and limits.
  Assumes a 32-bit AXI4-Lite register bus, one aligned word per register.
*/
package tt_proto_pkg;

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] WAKE_OFF = 8'h04;
  localparam logic [7:0] STATE_OFF = 8'h08;
  localparam logic [7:0] MTICK_OFF = 8'h0C;
  localparam logic [7:0] CORR_OFF = 8'h10;
  localparam logic [7:0] EXTCORR_OFF = 8'h14;
  localparam logic [7:0] LIMIT_OFF = 8'h18;
  localparam logic [7:0] SYNC_OFF = 8'h1C;
  localparam logic [7:0] FILTER_OFF = 8'h20;
  localparam logic [7:0] RXDATA_OFF = 8'h24;

  // ****************************************************************
  // Control and wake field positions
  // ****************************************************************
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_WAKE_BIT = 1;
  localparam int CTRL_INHIBIT_BIT = 2;
  localparam int CTRL_COLD_LO = 4;
  localparam int CTRL_MTRST_BIT = 8;
  localparam int WAKE_CHA_BIT = 0;
  localparam int WAKE_CHB_BIT = 1;
  localparam int WAKE_REP_LO = 4;
  localparam int CYCLE_MT_LO = 16;

  localparam logic [31:0] CTRL_RST = 32'h0000_0030;
  localparam logic [31:0] WAKE_RST = 32'h0000_0013;
  localparam logic [31:0] LIMIT_RST = 32'h0010_0010;
  localparam logic [15:0] CYCLE_MT_RST = 16'h0040;
  localparam logic [15:0] NIT_MT_RST = 16'h0008;
  localparam logic [15:0] WAKE_SYM_CLK = 16'h0020;

  // Fixed sync-node maximum; not configurable
  localparam logic [4:0] MAX_SYNC_NODES = 5'h10;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    ST_RESET, ST_CONFIG, ST_WAKE_SEND, ST_COLD_LISTEN, ST_COLD_START,
    ST_INTEG_LISTEN, ST_INIT_SCHED, ST_NORMAL
  } poc_state_e;

endpackage

// [tt_proto_core_properties.sv]
/* Port checker for the protocol core.
   Assumes it is bound to tt_proto_core with ce held high. */
`timescale 1ns/1ps
module tt_proto_checker (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic tx_null_ind,
  input wire logic table_clr_even,
  input wire logic table_clr_odd,
  input wire logic fifo_accept,
  input wire logic buf_accept
);
  // ********
  // Address of the read in flight
  // ********
  logic [7:0] ra_reg;
  logic [7:0] ra_next;
  logic st_rd;
  always_comb begin
    ra_next = ra_reg;
    if (!rst_n) ra_next = 8'h00;
    else if (s_axi_arvalid && s_axi_arready) ra_next = s_axi_araddr;
  end
  always_ff @(posedge mclk) ra_reg <= ra_next;
  assign st_rd = s_axi_rvalid && (ra_reg == tt_proto_pkg::STATE_OFF);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // ********
  // Properties
  // ********
  property p_null; tx_null_ind == 1'h0; endproperty
  a_null: assert property (p_null) else $error("null bit wrong");
  property p_clr; !(table_clr_even && table_clr_odd); endproperty
  a_clr: assert property (p_clr) else $error("both clears");
  property p_clr_len; $rose(table_clr_odd) |-> table_clr_odd [*8]; endproperty
  a_clr_len: assert property (p_clr_len) else $error("short clear");
  property p_fifo; fifo_accept |=> !fifo_accept; endproperty
  a_fifo: assert property (p_fifo) else $error("fifo pulse long");
  property p_buf; buf_accept |=> !buf_accept; endproperty
  a_buf: assert property (p_buf) else $error("buf pulse long");
  property p_wake; st_rd |-> s_axi_rdata[8] == 1'h0; endproperty
  a_wake: assert property (p_wake) else $error("wake seen");
  property p_sync;
    st_rd |-> s_axi_rdata[20:16] <= tt_proto_pkg::MAX_SYNC_NODES;
  endproperty
  a_sync: assert property (p_sync) else $error("sync over max");
  property p_unmap;
    s_axi_rvalid && ra_reg > tt_proto_pkg::RXDATA_OFF |->
      s_axi_rresp == tt_proto_pkg::RESP_SLVERR && s_axi_rdata == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read data moved");
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write resp moved");
endmodule
bind tt_proto_core tt_proto_checker tt_proto_checker_i (.mclk, .rst_n,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .tx_null_ind, .table_clr_even, .table_clr_odd, .fifo_accept, .buf_accept);

// [tt_node_model.sv]
/* Far-side cluster nodes as seen after line decoding.
   Assumes one caller task at a time, wake aside. */
`timescale 1ns/1ps
module tt_node_model (
  input wire logic mclk,
  output logic rx_frame_a,
  output logic rx_frame_b,
  output logic rx_sync,
  output logic rx_startup,
  output logic rx_null,
  output logic rx_wake_sym,
  output logic [31:0] rx_payload,
  output logic [10:0] rx_frame_id,
  output logic [5:0] rx_cycle,
  output logic [15:0] rx_msg_id,
  output logic [15:0] meas_offset,
  output logic [15:0] meas_rate
);
  initial begin
    {rx_frame_a, rx_frame_b, rx_sync, rx_startup, rx_wake_sym} = 5'h00;
    rx_null = 1'h1;
    {rx_payload, rx_frame_id, rx_cycle, rx_msg_id} = {65{1'h1}};
    {meas_offset, meas_rate} = 32'h0;
  end
  task automatic frame(input logic a, input logic b, input logic st,
                       input logic sy, input logic [31:0] pl);
    @(posedge mclk);
    {rx_frame_a, rx_frame_b, rx_startup, rx_sync} <= {a, b, st, sy};
    rx_null <= 1'h1;
    {rx_payload, rx_frame_id, rx_cycle, rx_msg_id} <= {pl, 33'h0};
    repeat (3) @(posedge mclk);
    {rx_frame_a, rx_frame_b, rx_startup, rx_sync} <= 4'h0;
    // Released data shows the inverse so stale values never match
    {rx_payload, rx_frame_id, rx_cycle, rx_msg_id} <= ~{pl, 33'h0};
    repeat (2) @(posedge mclk);
  endtask
  task automatic wake();
    @(posedge mclk);
    rx_wake_sym <= 1'h1;
    repeat (32) @(posedge mclk);
    rx_wake_sym <= 1'h0;
  endtask
  task automatic set_meas(input logic [15:0] o, input logic [15:0] r);
    @(posedge mclk);
    {meas_offset, meas_rate} <= {o, r};
  endtask
endmodule

// [test_timetriggered_bus_protocol_core.sv]
/* Self-checking bench for the protocol core.
   Assumes the package, core, checker and node model are compiled. */
`timescale 1ns/1ps
module test_timetriggered_bus_protocol_core;
  localparam int MT = 4;
  localparam logic [31:0] RUN = tt_proto_pkg::CTRL_RST | 32'h5;
  logic mclk = 1'h0;
  logic rst_n = 1'h0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'h0;
  logic wvalid = 1'h0;
  logic bready = 1'h0;
  logic arvalid = 1'h0;
  logic rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, d, pl;
  logic fa, fb, sy, st, nl, wk, wka, wkb, nul, clre, clro, facc, bacc;
  logic [10:0] fid;
  logic [5:0] cyc;
  logic [15:0] mid, mo, mr;
  int fails = 0;
  int n_checks = 0;
  int k;
  int n_fifo = 0;
  int n_buf = 0;
  always #5 mclk = ~mclk;
  // Accept pulses last one cycle, so they are tallied at every edge
  always @(posedge mclk) begin
    if (facc === 1'h1) n_fifo <= n_fifo + 1;
    if (bacc === 1'h1) n_buf <= n_buf + 1;
  end
  tt_proto_core #(.CLK_PER_MT(MT)) tt_proto_core_i (.mclk, .rst_n,
    .ce(1'h1), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .rx_frame_a(fa), .rx_frame_b(fb), .rx_sync(sy), .rx_startup(st),
    .rx_null(nl), .rx_wake_sym(wk), .rx_payload(pl), .rx_frame_id(fid),
    .rx_cycle(cyc), .rx_msg_id(mid), .meas_offset(mo), .meas_rate(mr),
    .tx_wake_a(wka), .tx_wake_b(wkb), .tx_null_ind(nul),
    .table_clr_even(clre), .table_clr_odd(clro), .fifo_accept(facc),
    .buf_accept(bacc));
  tt_node_model tt_node_model_i (.mclk, .rx_frame_a(fa), .rx_frame_b(fb),
    .rx_sync(sy), .rx_startup(st), .rx_null(nl), .rx_wake_sym(wk),
    .rx_payload(pl), .rx_frame_id(fid), .rx_cycle(cyc), .rx_msg_id(mid),
    .meas_offset(mo), .meas_rate(mr));
  // ********
  // Bus and report helpers
  // ********
  task automatic bad(input string m);
    fails++;
    $display("BAD %0t %s", $time, m);
  endtask
  function automatic bit miss(input bit ok);
    n_checks++;
    return !ok;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int n = 0;
    logic ah, wh, bh = 1'h0;
    @(posedge mclk);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, v, 3'h7};
    while (!bh && n < 1000) begin
      @(negedge mclk);
      {ah, wh, bh, r} = {awvalid & awready, wvalid & wready, bvalid, bresp};
      @(posedge mclk);
      if (ah) awvalid <= 1'h0;
      if (wh) wvalid <= 1'h0;
      n++;
    end
    bready <= 1'h0;
    if (!bh) bad("write timeout");
  endtask
  task automatic rd(input logic [7:0] a);
    int n = 0;
    logic ah, rh = 1'h0;
    @(posedge mclk);
    {araddr, arvalid, rready} <= {a, 2'h3};
    while (!rh && n < 1000) begin
      @(negedge mclk);
      {ah, rh, d, r} = {arvalid & arready, rvalid, rdata, rresp};
      @(posedge mclk);
      if (ah) arvalid <= 1'h0;
      n++;
    end
    rready <= 1'h0;
    if (!rh) bad("read timeout");
  endtask
  task automatic hold(ref logic s, input logic v, output int c);
    c = 0;
    while (s !== v && c < 1000) begin
      @(negedge mclk);
      c++;
    end
    if (c >= 1000) bad("level wait timeout");
  endtask
  task automatic wrap_up();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ********
  // Scenarios
  // ********
  task automatic t_regs();
    rd(tt_proto_pkg::CTRL_OFF);
    if (miss(d === tt_proto_pkg::CTRL_RST)) bad("ctrl reset value");
    rd(tt_proto_pkg::LIMIT_OFF);
    if (miss(d === tt_proto_pkg::LIMIT_RST)) bad("limit reset value");
    rd(8'h40);
    if (miss(r === tt_proto_pkg::RESP_SLVERR)) bad("unmapped read ok");
    wr(8'h44, 32'h1);
    if (miss(r === tt_proto_pkg::RESP_SLVERR)) bad("unmapped write ok");
  endtask
  task automatic t_wake();
    int ra = 0;
    logic pa = 1'h0, hb = 1'h0;
    wr(tt_proto_pkg::WAKE_OFF, 32'h21);
    wr(tt_proto_pkg::CTRL_OFF, tt_proto_pkg::CTRL_RST | 32'h2);
    fork tt_node_model_i.wake(); join_none
    repeat (1500) begin
      @(negedge mclk);
      if (wka && !pa) ra++;
      pa = wka;
      hb = hb | wkb;
    end
    if (miss(ra == 2 && hb === 1'h0)) bad("wake count or channel");
    rd(tt_proto_pkg::STATE_OFF);
    if (miss(d[3:0] === tt_proto_pkg::ST_CONFIG)) bad("no config");
    if (miss(d[8] === 1'h0)) bad("wake recognised");
  endtask
  task automatic t_start();
    wr(tt_proto_pkg::CTRL_OFF, RUN);
    wr(tt_proto_pkg::CTRL_OFF, RUN & ~32'h4);
    rd(tt_proto_pkg::CTRL_OFF);
    if (miss(d[2] === 1'h1)) bad("inhibit cleared");
    tt_node_model_i.frame(1'h1, 1'h0, 1'h1, 1'h0, 32'hA5A5_0001);
    tt_node_model_i.frame(1'h1, 1'h0, 1'h1, 1'h0, 32'hA5A5_0002);
    tt_node_model_i.frame(1'h0, 1'h1, 1'h1, 1'h0, 32'hA5A5_0003);
    rd(tt_proto_pkg::SYNC_OFF);
    if (miss(d === 32'h0001_0002)) bad("per-channel count");
    rd(tt_proto_pkg::RXDATA_OFF);
    if (miss(d === 32'h0)) bad("startup payload kept");
  endtask
  task automatic t_cycle();
    hold(clre, 1'h1, k);
    rd(tt_proto_pkg::MTICK_OFF);
    if (miss(d[16] === 1'h1)) bad("even clear not in odd");
    hold(clro, 1'h1, k);
    hold(clro, 1'h0, k);
    if (miss(k == tt_proto_pkg::NIT_MT_RST * MT)) bad("clear span");
    repeat (18) tt_node_model_i.frame(1'h1, 1'h0, 1'h0, 1'h1, 32'h0);
    rd(tt_proto_pkg::STATE_OFF);
    if (miss(d[20:16] === tt_proto_pkg::MAX_SYNC_NODES)) bad("sync cap");
  endtask
  task automatic t_mtick();
    wr(tt_proto_pkg::CTRL_OFF, RUN | 32'h100);
    rd(tt_proto_pkg::MTICK_OFF);
    if (miss(d[15:0] <= 16'h0001)) bad("macrotick not zeroed");
  endtask
  task automatic t_corr();
    wr(tt_proto_pkg::EXTCORR_OFF, 32'h0005_0005);
    tt_node_model_i.set_meas(16'h0100, 16'h0100);
    repeat (600) @(posedge mclk);
    rd(tt_proto_pkg::CORR_OFF);
    if (miss(d === 32'h0015_0015)) bad("correction clip order");
  endtask
  task automatic t_filter();
    int f0;
    int b0;
    rd(tt_proto_pkg::STATE_OFF);
    if (miss(d[3:0] === tt_proto_pkg::ST_NORMAL)) bad("not normal");
    // Channel A only, id 0, cycle 0, message id mask bit 8 set
    wr(tt_proto_pkg::FILTER_OFF, 32'h0100_0000);
    f0 = n_fifo;
    b0 = n_buf;
    tt_node_model_i.frame(1'h1, 1'h0, 1'h0, 1'h0, 32'h1234_5678);
    tt_node_model_i.frame(1'h0, 1'h1, 1'h0, 1'h0, 32'h5A5A_C3C3);
    if (miss(n_buf - b0 == 1)) bad("buffer filter");
    if (miss(n_fifo == f0)) bad("fifo ignored message id");
    rd(tt_proto_pkg::RXDATA_OFF);
    if (miss(d === 32'h5A5A_C3C3)) bad("normal payload lost");
  endtask
  initial begin
    repeat (20) @(posedge mclk);
    rst_n <= 1'h1;
    t_regs();
    t_wake();
    t_start();
    t_cycle();
    t_mtick();
    t_corr();
    t_filter();
    wrap_up();
  end
  initial begin
    repeat (20000) @(posedge mclk);
    bad("watchdog");
    wrap_up();
  end
endmodule
